// file: design/dio_port.sv
`timescale 1ns/100ps
// Behaviour
// (R1) Eight input lines and thirty-two output lines exist as separate numbered ports.
// (R2) Host commands set the outputs and read back the inputs.
// (R3) In alarm mode output line n follows alarm n, one to one, for alarms 1 to 32.
// (R4) Output lines 1 to 16 also drive the relay card slot.
// (R5) The trigger is detected on a rising or falling edge chosen by a setting.
// (R6) When enabled, a detected trigger sets a service-request condition for the host.
// (R7) After each scan is stored, the scan sync output gives one 100 ms pulse.
// (R8) A service-request mask decides whether the trigger may raise a request.
// (R9) Inputs are synchronised before use and outputs hold their last commanded value.
module dio_port (
  input wire logic clk,                          // System clock, 25 MHz
  input wire logic rst,                          // Synchronous reset, active high
  input wire dio_pkg::dio_cmd_t cmd,             // Host command
  input wire dio_pkg::dio_trig_cfg_t cfg,        // Trigger and request settings
  input wire logic [31:0] alarm,                 // Alarm states, bit n-1 is alarm n
  input wire logic [7:0] din_pin,                // Digital input pins
  input wire logic trig_pin,                     // External trigger pin
  input wire logic scan_stored,                  // Pulse: scan logged into buffer
  output logic [31:0] dout,                      // Digital output lines
  output logic [15:0] relay_out,                 // Relay card drive
  output logic [7:0] din_rd,                     // Input readback
  output logic trig_event,                       // Pulse: trigger detected
  output logic srq,                              // Service request to host
  output logic scan_sync                         // Scan sync pulse
);

  // ------------------------------------------------------------
  // Settings and command decode
  // ------------------------------------------------------------
  wire [1:0] cmd_op = cmd.op;
  wire [31:0] cmd_data = cmd.data;
  wire op_set_out = (cmd_op == dio_pkg::CMD_SET_OUT);
  wire op_alarm_mode = (cmd_op == dio_pkg::CMD_ALARM_MODE);
  wire mode_arg = cmd_data[0];

  wire edge_fall = cfg.trig_edge_fall;
  wire srq_en = cfg.trig_srq_en;
  wire srq_mask = cfg.srq_mask_trig;
  wire srq_clr = cfg.srq_clear;
  // Both the enable and the mask must let the trigger through
  wire srq_gate = srq_en & srq_mask; // R6 R8

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [8:0] sync_in;
  logic [8:0] sync_out;
  assign sync_in = {trig_pin, din_pin}; // R1

  // Every pin passes two flops before any logic reads it
  dio_sync #(
    .W(9)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d(sync_in),
    .q(sync_out)
  ); // R9

  wire [dio_pkg::DIN_W-1:0] din_s = sync_out[7:0];
  wire trig_s = sync_out[8];

  // ------------------------------------------------------------
  // Output mode
  // ------------------------------------------------------------
  logic alarm_mode_q;
  logic alarm_mode_d;

  // A direct write takes the lines away from the alarms
  assign alarm_mode_d = op_alarm_mode ? mode_arg :
                        (op_set_out ? 1'b0 : alarm_mode_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_mode_q <= 1'b1;
    end else begin
      alarm_mode_q <= alarm_mode_d; // R3
    end
  end

  // ------------------------------------------------------------
  // Output lines
  // ------------------------------------------------------------
  logic [dio_pkg::DOUT_W-1:0] dout_d;
  logic [dio_pkg::DOUT_W-1:0] dout_hold;

  assign dout_hold = op_set_out ? cmd_data : dout; // R2 R9
  assign dout_d = alarm_mode_d ? alarm : dout_hold; // R3

  always_ff @(posedge clk) begin
    if (rst) begin
      dout <= dio_pkg::DOUT_RST;
    end else begin
      dout <= dout_d; // R2 R3 R9
    end
  end

  // ------------------------------------------------------------
  // Relay card drive
  // ------------------------------------------------------------
  logic [dio_pkg::RELAY_W-1:0] relay_d;

  // The relay image leaves on the same edge as the lines it copies
  assign relay_d = dout_d[15:0]; // R4

  always_ff @(posedge clk) begin
    if (rst) begin
      relay_out <= dio_pkg::DOUT_RST[15:0];
    end else begin
      relay_out <= relay_d; // R4
    end
  end

  // ------------------------------------------------------------
  // Input readback
  // ------------------------------------------------------------
  // Readback shows the pins three edges after they change
  always_ff @(posedge clk) begin
    if (rst) begin
      din_rd <= 8'h00;
    end else begin
      din_rd <= din_s; // R2 R9
    end
  end

  // ------------------------------------------------------------
  // Trigger edge detector
  // ------------------------------------------------------------
  logic trig_prev_q;
  logic [1:0] arm_q;
  logic [1:0] arm_d;

  // Reset values in the synchroniser would look like an edge, so wait for pin data
  wire trig_armed = (arm_q == dio_pkg::TRIG_ARM_CNT);
  wire [1:0] arm_inc = arm_q + 2'h1;
  assign arm_d = trig_armed ? arm_q : arm_inc;

  wire rise = trig_s & ~trig_prev_q;
  wire fall = ~trig_s & trig_prev_q;
  wire edge_seen = edge_fall ? fall : rise; // R5
  wire trig_hit = edge_seen & trig_armed; // R5 R9

  always_ff @(posedge clk) begin
    if (rst) begin
      arm_q <= 2'h0;
    end else begin
      arm_q <= arm_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_s;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trig_event <= 1'b0;
    end else begin
      trig_event <= trig_hit; // R5
    end
  end

  // ------------------------------------------------------------
  // Service request
  // ------------------------------------------------------------
  wire srq_set = trig_hit & srq_gate; // R6 R8
  wire srq_keep = srq & ~srq_clr;

  // A trigger in the clearing cycle wins
  wire srq_d = srq_set | srq_keep;

  always_ff @(posedge clk) begin
    if (rst) begin
      srq <= 1'b0;
    end else begin
      srq <= srq_d; // R6
    end
  end

  // ------------------------------------------------------------
  // Scan sync pulse
  // ------------------------------------------------------------
  localparam logic [21:0] PULSE_LAST = 22'(dio_pkg::SCAN_PULSE_CYC - 1);

  logic [dio_pkg::PULSE_CNT_W-1:0] pulse_cnt_q;
  logic [dio_pkg::PULSE_CNT_W-1:0] pulse_cnt_d;
  logic [dio_pkg::PULSE_CNT_W-1:0] cnt_inc;

  // Counts from zero, so the pulse lasts the full cycle count
  wire pulse_start = scan_stored;
  wire pulse_busy = scan_sync;
  wire pulse_end = (pulse_cnt_q == PULSE_LAST);
  wire pulse_run = pulse_busy & ~pulse_end;
  assign cnt_inc = pulse_cnt_q + 22'h000001;

  // A scan logged during a pulse starts the pulse again
  assign pulse_cnt_d = pulse_start ? 22'h000000 :
                       (pulse_busy ? cnt_inc : pulse_cnt_q);
  wire sync_d = pulse_start | pulse_run; // R7

  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_cnt_q <= 22'h000000;
    end else begin
      pulse_cnt_q <= pulse_cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      scan_sync <= 1'b0;
    end else begin
      scan_sync <= sync_d; // R7
    end
  end

endmodule : dio_port

// file: shared/dio_pkg.sv
package dio_pkg;

  // ------------------------------------------------------------
  // Port sizes
  // ------------------------------------------------------------
  localparam int DIN_W = 8;
  localparam int DOUT_W = 32;
  localparam int RELAY_W = 16;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int SCAN_PULSE_MS = 100;
  localparam int SCAN_PULSE_CYC = CLK_HZ / 1000 * SCAN_PULSE_MS;
  localparam int PULSE_CNT_W = 22;
  localparam logic [1:0] TRIG_ARM_CNT = 2'h3;

  // ------------------------------------------------------------
  // Reset values and command codes
  // ------------------------------------------------------------
  localparam logic [31:0] DOUT_RST = 32'h0000_0000;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_SET_OUT = 2'h1;
  localparam logic [1:0] CMD_ALARM_MODE = 2'h2;

  typedef struct packed {
    logic [1:0] op;
    logic [31:0] data;
  } dio_cmd_t;

  typedef struct packed {
    logic trig_edge_fall;
    logic trig_srq_en;
    logic srq_mask_trig;
    logic srq_clear;
  } dio_trig_cfg_t;

endpackage : dio_pkg

// file: design/dio_sync.sv
`timescale 1ns/100ps
module dio_sync #(
  parameter int W = 1
) (
  input wire logic clk,          // System clock
  input wire logic rst,          // Synchronous reset
  input wire logic [W-1:0] d,    // Asynchronous input
  output logic [W-1:0] q         // Synchronised output
);
  logic [W-1:0] s1_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule : dio_sync

// file: verification/dio_ext.sv
`timescale 1ns/100ps
module dio_ext (input wire logic clk, input wire logic [8:0] req, output logic [8:0] pins);
  always @(posedge clk) pins <= req;
endmodule : dio_ext

// file: verification/dio_port_props.sv
`timescale 1ns/100ps
module dio_port_props (
  input wire logic clk, rst, trig_pin, scan_stored, trig_event, srq, scan_sync, // Bits
  input wire dio_pkg::dio_cmd_t cmd, input wire dio_pkg::dio_trig_cfg_t cfg, // Host side
  input wire logic [31:0] dout, input wire logic [15:0] relay_out // Outputs
);
  logic [2:0] up_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Counts edges since reset so the trigger history is valid
  always_ff @(posedge clk) up_q <= rst ? 3'h0 : up_q + 3'(up_q != 3'h7);
  chk_relay_copy: assert property (relay_out == dout[15:0]) else $error("relay");
  chk_cmd_out: assert property (cmd.op == dio_pkg::CMD_SET_OUT |=> dout == $past(cmd.data))
    else $error("set");
  chk_trig_edge: assert property (up_q == 3'h7 |-> trig_event ==
    ($past(trig_pin, 3) != $past(trig_pin, 4) &&
     $past(trig_pin, 3) != $past(cfg.trig_edge_fall)))
    else $error("edge");
  chk_srq_set: assert property (trig_event && $past(cfg.trig_srq_en) &&
    $past(cfg.srq_mask_trig) |-> srq) else $error("srq");
  chk_srq_gate: assert property ($rose(srq) |->
    trig_event && $past(cfg.trig_srq_en) && $past(cfg.srq_mask_trig)) else $error("gate");
  chk_srq_clear: assert property (srq && cfg.srq_clear |=> !srq || trig_event)
    else $error("clr");
  chk_srq_hold: assert property (srq && !cfg.srq_clear |=> srq) else $error("hold");
  chk_scan_pulse: assert property (scan_stored |=> scan_sync [*8]) else $error("scan");
endmodule : dio_port_props
bind dio_port dio_port_props u_p (.clk, .rst, .trig_pin, .scan_stored, .trig_event, .srq,
  .scan_sync, .cmd, .cfg, .dout, .relay_out);

// file: verification/tb_digital_io_trigger_port.sv
`timescale 1ns/100ps
module tb_digital_io_trigger_port;
  logic clk = 1'b0, rst = 1'b1, scan_stored = 1'b0, srq, scan_sync, trig_event, pre_lvl;
  logic [31:0] alarm = 32'h0, seed = 32'hc81ddfc8, dout, exp_out;
  logic [15:0] relay_out;
  logic [8:0] req = 9'h0, pins;
  logic [7:0] din_rd;
  dio_pkg::dio_cmd_t cmd = '0;
  dio_pkg::dio_trig_cfg_t cfg = '0;
  int num_errors = 0, n_tests = 0, n_trig = 0, base = 0;
  dio_ext u_ext (.clk, .req, .pins);
  dio_port DUT (.clk, .rst, .cmd, .cfg, .alarm, .din_pin(pins[7:0]), .trig_pin(pins[8]),
    .scan_stored, .dout, .relay_out, .din_rd, .trig_event, .srq, .scan_sync);
  // Trigger pulses last one cycle, so exactly one falling edge sees each pulse
  always @(negedge clk) n_trig += int'(trig_event);
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) $display("wrong value %0t: got %h want %h", $time, got, exp);
    num_errors += int'(got !== exp);
  endtask : check
  task automatic final_report();
    $display("errors %0d of %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  initial forever #20 clk = ~clk;
  initial begin
    #80000 num_errors++;
    final_report();
  end
  initial begin
    #200 rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      cmd.op = i[0] ? dio_pkg::CMD_SET_OUT : dio_pkg::CMD_ALARM_MODE;
      {cmd.data, scan_stored} = {i[0] ? seed : 32'h1, i == 7};
      @(negedge clk);
      {cmd.op, scan_stored} = {dio_pkg::CMD_NONE, 1'b0};
      {req, alarm} = {seed[8:0], ~seed};
      exp_out = i[0] ? seed : ~seed;
      repeat (6) @(negedge clk);
      check(dout, exp_out);
      check({16'h0, relay_out}, {16'h0, exp_out[15:0]});
      check({24'h0, din_rd}, {24'h0, seed[7:0]});
      check({31'h0, scan_sync}, {31'h0, i == 7});
    end
    // Alarm mode switched off by command: lines keep the last written value
    cmd = {dio_pkg::CMD_ALARM_MODE, 32'h0};
    @(negedge clk);
    cmd.op = dio_pkg::CMD_NONE;
    alarm = seed ^ 32'h5a5a_a5a5;
    repeat (3) @(negedge clk);
    check(dout, seed);
    // Bit 0 edge select, bit 1 mask, bit 2 enable, bit 3 drives the other edge
    for (int i = 0; i < 16; i++) begin
      cfg = {i[0], i[2], i[1], 1'b1};
      pre_lvl = i[0] ^ i[3];
      req[8] = pre_lvl;
      repeat (8) @(negedge clk);
      cfg.srq_clear = 1'b0;
      base = n_trig;
      req[8] = ~pre_lvl;
      repeat (8) @(negedge clk);
      check({31'h0, srq}, {31'h0, i[1] & i[2] & ~i[3]});
      check(32'(n_trig - base), {31'h0, ~i[3]});
    end
    // Reset in mid-run with the trigger pin high: no false edge afterwards
    cfg = 4'h6;
    base = n_trig;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check({31'h0, scan_sync}, 32'h0);
    check(dout, 32'h0);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    check(dout, alarm);
    check({31'h0, srq}, 32'h0);
    check(32'(n_trig - base), 32'h0);
    final_report();
  end
endmodule : tb_digital_io_trigger_port
